// ### verilog/tefc_top.sv
// Event register, fan controller and loop settings of the thermal controller.
// Assumes a command decoder on ref_clk delivering one command per strobe.
// Behaviour
// - Event bits 0-7 latch current, voltage, sensor, temperature and open faults.
// - Bit 9 out-of-tolerance change, bit 10 output change, bit 12 run-away.
// - Reading events returns contents and then clears them; an event set in the read cycle is kept.
// - Event mask, reset zero, selects bits forwarded to the summary status.
// - Mode 1 runs the fan only while controller output is on.
// - Mode 2 runs the fan continuously regardless of output state.
// - Mode 3 keeps fan running delay minutes, 1 to 240, after output off.
// - Mode 4 runs fan only while cooling; mode 5 only while heating.
// - Speed OFF, SLOW, MEDIUM, FAST give 0, 9, 10.5, 12 volts drive.
// - Explicit speed voltage accepted between 4.0 and 12.0 volts.
// - Fan write carries speed, optional mode, optional delay; query returns all.
// - Gain holds 1, 3, 5, 10, 30, 50, 100, 300 or PID; queryable.
// - Heat/cool holds BOTH, HEAT or COOL; query returns the selection.
module tefc_top
  import tefc_pkg::*;
#(
  parameter logic [MIN_CNT_W-1:0] MINUTE_TICKS = MIN_CNT_W'(MINUTE_CYCLES)
)(
  input  wire logic        ref_clk,     // 200 MHz system clock
  input  wire logic        sys_rst,     // Synchronous reset, high
  input  wire logic        cmdValid,    // Command strobe
  input  wire logic [3:0]  cmdCode,     // Command code
  input  wire logic [31:0] cmdData,     // Command argument
  input  wire logic [7:0]  faultCond,   // Limit and fault levels
  input  wire logic        outOfTol,    // Out-of-tolerance level
  input  wire logic        outputOn,    // Controller output on
  input  wire logic        runawayHit,  // Thermal run-away pulse
  input  wire logic        cooling,     // Loop is cooling
  input  wire logic        heating,     // Loop is heating
  output logic             rspValid,    // Query answer strobe
  output logic      [31:0] rspData,     // Query answer
  output logic             cmdReject,   // Bad argument strobe
  output logic             eventSummary,// Masked events present
  output logic             fanRun,      // Fan drive enable
  output logic      [7:0]  fanDrive,    // Fan volts in tenths
  output logic      [3:0]  loopGain,    // Gain selection
  output logic      [1:0]  thermalDir   // Heat/cool selection
);

  logic [15:0] events;
  logic [15:0] evtSet;
  logic        evtRead;
  logic [7:0]  lastFault;
  logic        lastTol;
  logic        lastOn;
  logic [7:0]  next_lastFault;
  logic        next_lastTol;
  logic        next_lastOn;
  logic        delayHold;

  logic [15:0] eventMask;
  logic [15:0] next_eventMask;
  logic [2:0]  fanSel;
  logic [2:0]  next_fanSel;
  logic [7:0]  fanVolts;
  logic [7:0]  next_fanVolts;
  logic [2:0]  fanMode;
  logic [2:0]  next_fanMode;
  logic [7:0]  fanDelay;
  logic [7:0]  next_fanDelay;
  logic [3:0]  next_loopGain;
  logic [1:0]  next_thermalDir;
  logic        next_rspValid;
  logic [31:0] next_rspData;
  logic        next_cmdReject;
  logic        next_eventSummary;
  logic        next_fanRun;
  logic [7:0]  next_fanDrive;

  logic [2:0]  argSel;
  logic [7:0]  argVolts;
  logic [2:0]  argMode;
  logic [7:0]  argDelay;
  logic        argModePres;
  logic        argDelayPres;
  logic        argModeOk;
  logic        argDelayOk;
  logic        fanArgOk;

  // Checks that a speed selection and voltage code are legal
  function automatic logic speed_ok(input logic [2:0] sel, input logic [7:0] volts);
    speed_ok = (sel <= SPD_FAST) ||
               ((sel == SPD_EXPLICIT) && (volts >= VOLT_MIN) && (volts <= VOLT_MAX));
  endfunction

  // Drive level for a speed selection
  function automatic logic [7:0] speed_volts(input logic [2:0] sel, input logic [7:0] volts);
    unique case (sel)
      SPD_SLOW:     speed_volts = VOLT_SLOW;
      SPD_MEDIUM:   speed_volts = VOLT_MEDIUM;
      SPD_FAST:     speed_volts = VOLT_FAST;
      SPD_EXPLICIT: speed_volts = volts;
      default:      speed_volts = 8'h00;
    endcase
  endfunction

  // Fan argument fields
  assign argSel       = cmdData[FAN_SEL_LSB +: 3];
  assign argVolts     = cmdData[FAN_VOLT_LSB +: 8];
  assign argModePres  = cmdData[FAN_MODE_PRES];
  assign argMode      = cmdData[FAN_MODE_LSB +: 3];
  assign argDelayPres = cmdData[FAN_DELAY_PRES];
  assign argDelay     = cmdData[FAN_DELAY_LSB +: 8];
  assign argModeOk    = !argModePres || ((argMode >= FAN_AUTO) && (argMode <= FAN_HEAT_ONLY));
  assign argDelayOk   = !argDelayPres || ((argDelay >= DELAY_MIN) && (argDelay <= DELAY_MAX));
  assign fanArgOk     = speed_ok(argSel, argVolts) && argModeOk && argDelayOk;

  // Event sources: fault edges, state changes, run-away pulse
  always_comb begin
    evtSet                 = 16'h0000;
    evtSet[7:0]            = faultCond & ~lastFault;
    evtSet[EVT_TOL_CHANGE] = outOfTol ^ lastTol;
    evtSet[EVT_OUT_CHANGE] = outputOn ^ lastOn;
    evtSet[EVT_RUNAWAY]    = runawayHit;
  end

  // Edge detectors follow their inputs
  always_comb begin
    next_lastFault = faultCond;
    next_lastTol   = outOfTol;
    next_lastOn    = outputOn;
  end

  assign evtRead = cmdValid && (cmdCode == CMD_EVT_QUERY);

  // Sticky event register
  tefc_event_latch u_events (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .setBits   (evtSet),
    .clearRead (evtRead),
    .events    (events)
  );

  // Delayed switch-off timer
  tefc_fan_timer #(
    .MINUTE_TICKS (MINUTE_TICKS)
  ) u_timer (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .enable   (fanMode == FAN_DELAYED),
    .outputOn (outputOn),
    .delayMin (fanDelay),
    .holdRun  (delayHold)
  );

  // Command handling and query answers
  always_comb begin
    next_eventMask  = eventMask;
    next_fanSel     = fanSel;
    next_fanVolts   = fanVolts;
    next_fanMode    = fanMode;
    next_fanDelay   = fanDelay;
    next_loopGain   = loopGain;
    next_thermalDir = thermalDir;
    next_rspValid   = 1'b0;
    next_rspData    = 32'h00000000;
    next_cmdReject  = 1'b0;
    if (cmdValid) begin
      case (cmdCode)
        CMD_EVT_QUERY: begin
          next_rspValid = 1'b1;
          next_rspData  = {16'h0000, events};
        end
        CMD_MASK_WRITE: begin
          next_eventMask = cmdData[15:0];
        end
        CMD_MASK_QUERY: begin
          next_rspValid = 1'b1;
          next_rspData  = {16'h0000, eventMask};
        end
        CMD_FAN_WRITE: begin
          if (fanArgOk) begin
            next_fanSel   = argSel;
            next_fanVolts = (argSel == SPD_EXPLICIT) ? argVolts : 8'h00;
            if (argModePres) begin
              next_fanMode = argMode;
            end
            if (argDelayPres) begin
              next_fanDelay = argDelay;
            end
          end else begin
            next_cmdReject = 1'b1;
          end
        end
        CMD_FAN_QUERY: begin
          next_rspValid = 1'b1;
          next_rspData  = {8'h00, fanDelay, 1'b0, fanMode, 1'b0, fanVolts, fanSel};
        end
        CMD_GAIN_WRITE: begin
          if (cmdData[3:0] <= GAIN_PID) begin
            next_loopGain = cmdData[3:0];
          end else begin
            next_cmdReject = 1'b1;
          end
        end
        CMD_GAIN_QUERY: begin
          next_rspValid = 1'b1;
          next_rspData  = {28'h0000000, loopGain};
        end
        CMD_DIR_WRITE: begin
          if (cmdData[1:0] <= DIR_COOL) begin
            next_thermalDir = cmdData[1:0];
          end else begin
            next_cmdReject = 1'b1;
          end
        end
        CMD_DIR_QUERY: begin
          next_rspValid = 1'b1;
          next_rspData  = {30'h00000000, thermalDir};
        end
        default: begin
          next_cmdReject = 1'b1;
        end
      endcase
    end
  end

  // Summary of enabled events
  always_comb begin
    next_eventSummary = |(events & eventMask);
  end

  // Fan run decision per mode
  always_comb begin
    next_fanRun = 1'b0;
    case (fanMode)
      FAN_AUTO:      next_fanRun = outputOn;
      FAN_ALWAYS:    next_fanRun = 1'b1;
      // Last output state bridges the cycle before the timer starts
      FAN_DELAYED:   next_fanRun = outputOn || lastOn || delayHold;
      FAN_COOL_ONLY: next_fanRun = cooling;
      FAN_HEAT_ONLY: next_fanRun = heating;
      default:       next_fanRun = 1'b0;
    endcase
    if (fanSel == SPD_OFF) begin
      next_fanRun = 1'b0;
    end
    next_fanDrive = next_fanRun ? speed_volts(fanSel, fanVolts) : 8'h00;
  end

  // Settings and query answer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eventMask  <= MASK_RESET;
      fanSel     <= FAN_SEL_RESET;
      fanVolts   <= FAN_VOLT_RESET;
      fanMode    <= FAN_MODE_RESET;
      fanDelay   <= FAN_DELAY_RESET;
      loopGain   <= GAIN_1;
      thermalDir <= DIR_BOTH;
      rspValid   <= 1'b0;
      rspData    <= 32'h00000000;
      cmdReject  <= 1'b0;
    end else begin
      eventMask  <= next_eventMask;
      fanSel     <= next_fanSel;
      fanVolts   <= next_fanVolts;
      fanMode    <= next_fanMode;
      fanDelay   <= next_fanDelay;
      loopGain   <= next_loopGain;
      thermalDir <= next_thermalDir;
      rspValid   <= next_rspValid;
      rspData    <= next_rspData;
      cmdReject  <= next_cmdReject;
    end
  end

  // Summary register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eventSummary <= 1'b0;
    end else begin
      eventSummary <= next_eventSummary;
    end
  end

  // Fan drive registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fanRun   <= 1'b0;
      fanDrive <= 8'h00;
    end else begin
      fanRun   <= next_fanRun;
      fanDrive <= next_fanDrive;
    end
  end

  // Edge detector registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lastFault <= 8'h00;
      lastTol   <= 1'b0;
      lastOn    <= 1'b0;
    end else begin
      lastFault <= next_lastFault;
      lastTol   <= next_lastTol;
      lastOn    <= next_lastOn;
    end
  end

endmodule

// ### verilog/tefc_pkg.sv
// Shared constants for the thermal event and fan control block.
// Assumes one 200 MHz clock and a command decoder in front of the block.
package tefc_pkg;

  // Clock and timing
  localparam longint CLK_HZ           = 200000000;
  localparam longint MINUTE_S         = 60;
  localparam longint MINUTE_CYCLES    = MINUTE_S * CLK_HZ;
  localparam int     MIN_CNT_W        = 36;

  // Event bit positions
  localparam int EVT_CUR_LIMIT   = 0;
  localparam int EVT_VOLT_LIMIT  = 1;
  localparam int EVT_SENS_LIMIT  = 2;
  localparam int EVT_TEMP_HIGH   = 3;
  localparam int EVT_TEMP_LOW    = 4;
  localparam int EVT_SENS_SHORT  = 5;
  localparam int EVT_SENS_OPEN   = 6;
  localparam int EVT_LOAD_OPEN   = 7;
  localparam int EVT_TOL_CHANGE  = 9;
  localparam int EVT_OUT_CHANGE  = 10;
  localparam int EVT_RUNAWAY     = 12;
  localparam logic [15:0] EVT_USED_MASK = 16'h16FF;
  localparam logic [15:0] EVT_RESET     = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;

  // Command codes
  localparam logic [3:0] CMD_EVT_QUERY  = 4'h1;
  localparam logic [3:0] CMD_MASK_WRITE = 4'h2;
  localparam logic [3:0] CMD_MASK_QUERY = 4'h3;
  localparam logic [3:0] CMD_FAN_WRITE  = 4'h4;
  localparam logic [3:0] CMD_FAN_QUERY  = 4'h5;
  localparam logic [3:0] CMD_GAIN_WRITE = 4'h6;
  localparam logic [3:0] CMD_GAIN_QUERY = 4'h7;
  localparam logic [3:0] CMD_DIR_WRITE  = 4'h8;
  localparam logic [3:0] CMD_DIR_QUERY  = 4'h9;

  // Fan command field layout
  localparam int FAN_SEL_LSB    = 0;
  localparam int FAN_VOLT_LSB   = 3;
  localparam int FAN_MODE_PRES  = 11;
  localparam int FAN_MODE_LSB   = 12;
  localparam int FAN_DELAY_PRES = 15;
  localparam int FAN_DELAY_LSB  = 16;

  // Speed selections and drive levels in tenths of a volt
  localparam logic [2:0] SPD_OFF      = 3'h0;
  localparam logic [2:0] SPD_SLOW     = 3'h1;
  localparam logic [2:0] SPD_MEDIUM   = 3'h2;
  localparam logic [2:0] SPD_FAST     = 3'h3;
  localparam logic [2:0] SPD_EXPLICIT = 3'h4;
  localparam logic [7:0] VOLT_SLOW    = 8'h5A;
  localparam logic [7:0] VOLT_MEDIUM  = 8'h69;
  localparam logic [7:0] VOLT_FAST    = 8'h78;
  localparam logic [7:0] VOLT_MIN     = 8'h28;
  localparam logic [7:0] VOLT_MAX     = 8'h78;

  // Fan modes and delay range
  localparam logic [2:0] FAN_AUTO      = 3'h1;
  localparam logic [2:0] FAN_ALWAYS    = 3'h2;
  localparam logic [2:0] FAN_DELAYED   = 3'h3;
  localparam logic [2:0] FAN_COOL_ONLY = 3'h4;
  localparam logic [2:0] FAN_HEAT_ONLY = 3'h5;
  localparam logic [7:0] DELAY_MIN     = 8'h01;
  localparam logic [7:0] DELAY_MAX     = 8'hF0;

  // Gain selections
  localparam logic [3:0] GAIN_1    = 4'h0;
  localparam logic [3:0] GAIN_PID  = 4'h8;

  // Heat/cool selections
  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_HEAT = 2'h1;
  localparam logic [1:0] DIR_COOL = 2'h2;

  // Reset values of settings
  localparam logic [2:0] FAN_SEL_RESET   = SPD_OFF;
  localparam logic [7:0] FAN_VOLT_RESET  = 8'h00;
  localparam logic [2:0] FAN_MODE_RESET  = FAN_AUTO;
  localparam logic [7:0] FAN_DELAY_RESET = DELAY_MIN;

endpackage

// ### verilog/tefc_event_latch.sv
// Sticky 16-bit event register with clear on read.
// Assumes set pulses and the clear strobe come from logic on ref_clk.
module tefc_event_latch
  import tefc_pkg::*;
(
  input  wire logic        ref_clk,   // System clock
  input  wire logic        sys_rst,   // Synchronous reset
  input  wire logic [15:0] setBits,   // Event pulses
  input  wire logic        clearRead, // Clearing read strobe
  output logic      [15:0] events     // Latched events
);

  logic [15:0] next_events;

  // Set wins over the read clear; unused bits stay zero
  always_comb begin
    next_events = clearRead ? 16'h0000 : events;
    next_events = (next_events | setBits) & EVT_USED_MASK;
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      events <= EVT_RESET;
    end else begin
      events <= next_events;
    end
  end

endmodule

// ### verilog/tefc_fan_timer.sv
// Minute-based switch-off delay for the delayed fan mode.
// Assumes outputOn is a level from logic on ref_clk.
module tefc_fan_timer
  import tefc_pkg::*;
#(
  parameter logic [MIN_CNT_W-1:0] MINUTE_TICKS = MIN_CNT_W'(MINUTE_CYCLES)
)(
  input  wire logic       ref_clk,   // System clock
  input  wire logic       sys_rst,   // Synchronous reset
  input  wire logic       enable,    // Delayed mode active
  input  wire logic       outputOn,  // Controller output state
  input  wire logic [7:0] delayMin,  // Programmed delay in minutes
  output logic            holdRun    // Fan kept running by delay
);

  typedef enum logic [1:0] {
    T_IDLE  = 2'b01,
    T_DELAY = 2'b10
  } tefc_tstate_t;

  tefc_tstate_t         state;
  tefc_tstate_t         next_state;
  logic [MIN_CNT_W-1:0] prescale;
  logic [MIN_CNT_W-1:0] next_prescale;
  logic [7:0]           remaining;
  logic [7:0]           next_remaining;
  logic                 lastOn;
  logic                 minuteTick;

  assign minuteTick = (prescale == MINUTE_TICKS - MIN_CNT_W'(1));
  assign holdRun    = (state == T_DELAY);

  // Delay sequencing
  always_comb begin
    next_state     = state;
    next_prescale  = prescale;
    next_remaining = remaining;
    unique case (state)
      T_IDLE: begin
        if (enable && lastOn && !outputOn) begin
          next_state     = T_DELAY;
          next_prescale  = '0;
          next_remaining = delayMin;
        end
      end
      T_DELAY: begin
        if (!enable || outputOn) begin
          next_state = T_IDLE;
        end else if (minuteTick) begin
          next_prescale  = '0;
          next_remaining = remaining - 8'h01;
          if (remaining == 8'h01) begin
            next_state = T_IDLE;
          end
        end else begin
          next_prescale = prescale + MIN_CNT_W'(1);
        end
      end
    endcase
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state     <= T_IDLE;
      prescale  <= '0;
      remaining <= 8'h00;
      lastOn    <= 1'b0;
    end else begin
      state     <= next_state;
      prescale  <= next_prescale;
      remaining <= next_remaining;
      lastOn    <= outputOn;
    end
  end

endmodule

// ### dv/tefc_checker.sv
// Concurrent checks on the ports of the thermal event and fan control block.
// Assumes single ref_clk domain and synchronous active-high sys_rst.
module tefc_checker
  import tefc_pkg::*;
#(
  parameter logic [MIN_CNT_W-1:0] MINUTE_TICKS = MIN_CNT_W'(MINUTE_CYCLES)
)(
  input wire logic        ref_clk,   // System clock
  input wire logic        sys_rst,   // Synchronous reset
  input wire logic        cmdValid,  // Command strobe
  input wire logic [3:0]  cmdCode,   // Command code
  input wire logic [31:0] cmdData,   // Command argument
  input wire logic        rspValid,  // Answer strobe
  input wire logic [31:0] rspData,   // Answer data
  input wire logic        cmdReject, // Refusal strobe
  input wire logic        fanRun,    // Fan enable
  input wire logic [7:0]  fanDrive,  // Fan volts in tenths
  input wire logic [3:0]  loopGain,  // Gain selection
  input wire logic [1:0]  thermalDir // Heat/cool selection
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Query answers and refusals
  query_answer_a: assert property (cmdValid && cmdCode == CMD_EVT_QUERY |=> rspValid)
    else $error("event query gave no answer");
  unused_bits_a: assert property (rspValid && $past(cmdValid && cmdCode == CMD_EVT_QUERY)
    |-> (rspData[15:0] & ~EVT_USED_MASK) == 16'h0000)
    else $error("unused event bit set");
  reject_code_a: assert property (cmdValid && cmdCode == 4'hF |=> cmdReject && !rspValid)
    else $error("unknown code not refused");
  // Setting writes
  gain_follow_a: assert property (cmdValid && cmdCode == CMD_GAIN_WRITE && cmdData[3:0] <= GAIN_PID
    |=> loopGain == $past(cmdData[3:0]) && !cmdReject && !rspValid)
    else $error("gain not taken");
  gain_refuse_a: assert property (cmdValid && cmdCode == CMD_GAIN_WRITE && cmdData[3:0] > GAIN_PID
    |=> cmdReject && $stable(loopGain))
    else $error("bad gain not refused");
  dir_follow_a: assert property (cmdValid && cmdCode == CMD_DIR_WRITE && cmdData[1:0] != 2'h3
    |=> thermalDir == $past(cmdData[1:0]))
    else $error("direction not taken");
  // Fan drive levels
  drive_off_a: assert property (!fanRun |-> fanDrive == 8'h00)
    else $error("drive while fan stopped");
  drive_range_a: assert property (fanRun |-> fanDrive >= VOLT_MIN && fanDrive <= VOLT_MAX)
    else $error("drive outside range");

  fan_start_c: cover property ($rose(fanRun));
  reject_c: cover property (cmdReject);
  event_read_c: cover property (rspValid && rspData[12]);
endmodule

bind tefc_top tefc_checker #(.MINUTE_TICKS(MINUTE_TICKS)) tefc_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
  .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .cmdReject(cmdReject),
  .fanRun(fanRun), .fanDrive(fanDrive), .loopGain(loopGain), .thermalDir(thermalDir)
);

// ### dv/tefc_host_model.sv
// Host side model: issues one decoded command and collects the answer.
// Assumes commands are driven at the falling edge of ref_clk.
module tefc_host_model
  import tefc_pkg::*;
(
  input  wire logic        ref_clk,   // System clock
  output logic             cmdValid,  // Command strobe
  output logic      [3:0]  cmdCode,   // Command code
  output logic      [31:0] cmdData,   // Command argument
  input  wire logic        rspValid,  // Answer strobe
  input  wire logic [31:0] rspData,   // Answer data
  input  wire logic        cmdReject  // Refusal strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines at time zero
  initial begin
    cmdValid = 1'b0;
    cmdCode  = 4'h0;
    cmdData  = 32'h0;
  end

  // One command held across its taking edge; idle lines then show the inverse
  task automatic issue(input logic [3:0] code, input logic [31:0] data,
                       output logic rv, output logic rej, output logic [31:0] rsp);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdCode  = code;
    cmdData  = data;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    cmdCode  = ~code;
    cmdData  = ~data;
    rv  = rspValid;
    rej = cmdReject;
    rsp = rspData;
  endtask
endmodule

// ### dv/test_tefc_top.sv
// Self-checking bench for the thermal event and fan control block.
// Assumes the host model drives commands; a minute is shortened to 10 cycles.
module test_tefc_top
  import tefc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [MIN_CNT_W-1:0] TICKS = MIN_CNT_W'(10);
  logic ref_clk = 1'b0, sys_rst = 1'b1, cmdValid, rspValid, cmdReject, eventSummary;
  logic outOfTol = 1'b0, outputOn = 1'b0, runawayHit = 1'b0, cooling = 1'b0;
  logic heating = 1'b0, fanRun;
  logic [7:0]  faultCond = 8'h00, fanDrive;
  logic [3:0]  cmdCode, loopGain;
  logic [31:0] cmdData, rspData;
  logic [1:0]  thermalDir;
  int bad_count = 0, cmp_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  tefc_top #(.MINUTE_TICKS(TICKS)) tefc_top_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .faultCond(faultCond), .outOfTol(outOfTol), .outputOn(outputOn),
    .runawayHit(runawayHit), .cooling(cooling), .heating(heating), .rspValid(rspValid),
    .rspData(rspData), .cmdReject(cmdReject), .eventSummary(eventSummary),
    .fanRun(fanRun), .fanDrive(fanDrive), .loopGain(loopGain), .thermalDir(thermalDir));
  tefc_host_model tefc_host_model_inst (
    .ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData), .cmdReject(cmdReject));

  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Command helpers
  task automatic query(input logic [3:0] code, input logic [31:0] exp);
    logic rv, rej;
    logic [31:0] rsp;
    tefc_host_model_inst.issue(code, 32'h0, rv, rej, rsp);
    chk({31'h0, rv}, 32'h1);
    chk(rsp, exp);
  endtask
  task automatic write(input logic [3:0] code, input logic [31:0] data, input logic expRej);
    logic rv, rej;
    logic [31:0] rsp;
    tefc_host_model_inst.issue(code, data, rv, rej, rsp);
    chk({31'h0, rej}, {31'h0, expRej});
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse_runaway();
    runawayHit = 1'b1;
    @(negedge ref_clk);
    runawayHit = 1'b0;
  endtask
  function automatic logic [31:0] fan_word(input logic [2:0] sel, input logic [7:0] volts,
                                           input logic [2:0] mode, input logic [7:0] dly);
    return {8'h00, dly, 1'b1, mode, 1'b1, volts, sel};
  endfunction
  task automatic fan_case(input logic [2:0] sel, input logic [7:0] volts, input logic [2:0] mode,
                          input logic [7:0] dly, input logic [2:0] lvl, input logic expRun,
                          input logic [7:0] expDrv);
    {outputOn, cooling, heating} = lvl;
    write(CMD_FAN_WRITE, fan_word(sel, volts, mode, dly), 1'b0);
    waitc(3);
    chk({31'h0, fanRun}, {31'h0, expRun});
    chk({24'h0, fanDrive}, {24'h0, expDrv});
  endtask

  // Main sequence
  initial begin
    waitc(8);
    sys_rst = 1'b0;
    query(CMD_FAN_QUERY, 32'h0001_1000);
    query(CMD_MASK_QUERY, 32'h0);
    query(CMD_EVT_QUERY, 32'h0);
    for (int i = 0; i < 8; i++) begin
      faultCond = 8'h01 << i;
      query(CMD_EVT_QUERY, 32'h1 << i);
      faultCond = 8'h00;
    end
    outOfTol = 1'b1;
    query(CMD_EVT_QUERY, 32'h0200);
    outputOn = 1'b1;
    query(CMD_EVT_QUERY, 32'h0400);
    outputOn = 1'b0;
    pulse_runaway();
    query(CMD_EVT_QUERY, 32'h1400);
    fork
      query(CMD_EVT_QUERY, 32'h0);
      begin
        @(negedge ref_clk);
        pulse_runaway();
      end
    join
    query(CMD_EVT_QUERY, 32'h1000);
    write(CMD_MASK_WRITE, 32'h1000, 1'b0);
    query(CMD_MASK_QUERY, 32'h1000);
    faultCond = 8'h01;
    waitc(4);
    chk({31'h0, eventSummary}, 32'h0);
    pulse_runaway();
    waitc(3);
    chk({31'h0, eventSummary}, 32'h1);
    query(CMD_EVT_QUERY, 32'h1001);
    waitc(3);
    chk({31'h0, eventSummary}, 32'h0);
    faultCond = 8'h00;
    fan_case(SPD_SLOW, 8'h00, FAN_AUTO, 8'hF0, 3'b000, 1'b0, 8'h00);
    fan_case(SPD_SLOW, 8'h00, FAN_AUTO, 8'h01, 3'b100, 1'b1, VOLT_SLOW);
    fan_case(SPD_MEDIUM, 8'h00, FAN_ALWAYS, 8'h01, 3'b000, 1'b1, VOLT_MEDIUM);
    fan_case(SPD_EXPLICIT, 8'h28, FAN_COOL_ONLY, 8'h01, 3'b010, 1'b1, 8'h28);
    fan_case(SPD_EXPLICIT, 8'h28, FAN_COOL_ONLY, 8'h01, 3'b101, 1'b0, 8'h00);
    fan_case(SPD_FAST, 8'h00, FAN_HEAT_ONLY, 8'h01, 3'b001, 1'b1, VOLT_FAST);
    fan_case(SPD_OFF, 8'h00, FAN_ALWAYS, 8'h01, 3'b100, 1'b0, 8'h00);
    fan_case(SPD_EXPLICIT, 8'h50, FAN_DELAYED, 8'h02, 3'b100, 1'b1, 8'h50);
    query(CMD_FAN_QUERY, {8'h00, 8'h02, 1'b0, 3'h3, 1'b0, 8'h50, 3'h4});
    outputOn = 1'b0;
    waitc(12);
    chk({31'h0, fanRun}, 32'h1);
    waitc(15);
    chk({31'h0, fanRun}, 32'h0);
    outputOn = 1'b1;
    waitc(3);
    outputOn = 1'b0;
    waitc(10);
    outputOn = 1'b1;
    waitc(3);
    outputOn = 1'b0;
    waitc(15);
    chk({31'h0, fanRun}, 32'h1);
    waitc(10);
    chk({31'h0, fanRun}, 32'h0);
    write(CMD_FAN_WRITE, 32'h1, 1'b0);
    query(CMD_FAN_QUERY, {8'h00, 8'h02, 1'b0, 3'h3, 1'b0, 8'h00, 3'h1});
    write(CMD_FAN_WRITE, fan_word(SPD_EXPLICIT, 8'h27, FAN_AUTO, 8'h01), 1'b1);
    write(CMD_FAN_WRITE, fan_word(SPD_EXPLICIT, 8'h79, FAN_AUTO, 8'h01), 1'b1);
    write(CMD_FAN_WRITE, fan_word(SPD_SLOW, 8'h00, 3'h6, 8'h01), 1'b1);
    write(CMD_FAN_WRITE, fan_word(SPD_SLOW, 8'h00, FAN_DELAYED, 8'h00), 1'b1);
    write(CMD_FAN_WRITE, fan_word(SPD_SLOW, 8'h00, FAN_DELAYED, 8'hF1), 1'b1);
    write(4'hF, 32'h0, 1'b1);
    query(CMD_FAN_QUERY, {8'h00, 8'h02, 1'b0, 3'h3, 1'b0, 8'h00, 3'h1});
    for (int g = 0; g < 10; g++) begin
      write(CMD_GAIN_WRITE, 32'(g), g > 8);
      query(CMD_GAIN_QUERY, (g > 8) ? 32'h8 : 32'(g));
      chk({28'h0, loopGain}, (g > 8) ? 32'h8 : 32'(g));
    end
    for (int d = 0; d < 4; d++) begin
      write(CMD_DIR_WRITE, 32'(d), d == 3);
      query(CMD_DIR_QUERY, (d == 3) ? 32'h2 : 32'(d));
      chk({30'h0, thermalDir}, (d == 3) ? 32'h2 : 32'(d));
    end
    wrap_up();
  end

  // Watchdog well beyond the expected run of about 250 cycles
  initial begin
    #50us;
    bad_count++;
    wrap_up();
  end
endmodule
